// ---- fre_pkg.sv ----
// Summary of operation
// - running code erases flash only as whole rows, never words
// - only 55h, then AAh, then write-start may launch an operation
// - write-start is followed by two forced no-operation instruction slots
// - a row erase halts the core for the erase time, typically 2 ms
// - the stall is no sleep; clocks and peripherals keep running
// - after an erase the core resumes at the third instruction
// - programming never erases; target words must be blank already
// - one program writes up to the 32 write latches
// - address bits 14..5 pick the row, bits 4..0 pick the latch
// - a program stays inside one row and never spills over
// - every finished program or erase sets all latches to 3fffh
// - with latch-load-only set and erase select clear, unlock only loads the addressed latch
// - with latch-load-only and erase select clear, unlock loads the latch, then programs row
// - a broken unlock loads no latch and starts no operation
// - latches not loaded keep the blank value during a partial program
// - after the two slots of a program the core stalls until done
// - a latch-load-only operation forces two slots and never stalls
// - start bits are set-only for software and cleared by hardware
// - a reset that interrupts a write sets the write-error flag
package fre_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned ERASE_TIME_US = 2000;
    localparam int unsigned ERASE_CYCLES =
        ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned CLKS_PER_INSTR = 4;
    localparam int unsigned NOP_SLOTS = 2;
    localparam int unsigned NOP_CYCLES = NOP_SLOTS * CLKS_PER_INSTR;
    localparam int unsigned LATCHES = 32;
    localparam int unsigned TMR_W = 20;
    localparam logic [13:0] BLANK_WORD = 14'h3fff;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [2:0] REG_DATA_LO = 3'h0;
    localparam logic [2:0] REG_DATA_HI = 3'h1;
    localparam logic [2:0] REG_ADDR_LO = 3'h2;
    localparam logic [2:0] REG_ADDR_HI = 3'h3;
    localparam logic [2:0] REG_CTRL = 3'h4;
    localparam logic [2:0] REG_KEY = 3'h5;
    localparam int unsigned CTL_RD = 0;
    localparam int unsigned CTL_WR = 1;
    localparam int unsigned CTL_WRITE_ENABLE_BIT = 2;
    localparam int unsigned CTL_WRITE_ERROR_FLAG = 3;
    localparam int unsigned CTL_FREE = 4;
    localparam int unsigned CTL_LATCH_LOAD_ONLY = 5;
    localparam int unsigned CTL_CONFIG_SPACE_SELECT = 6;
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT1 = 2'b01,
        KEY_GOT2 = 2'b10
    } fre_key_st_t;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SETUP = 2'b01,
        SEQ_STALL = 2'b10,
        SEQ_DONE = 2'b11
    } fre_seq_st_t;
    typedef enum logic [1:0] {
        OP_LOAD = 2'b00,
        OP_PROG = 2'b01,
        OP_ERASE = 2'b10
    } fre_op_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } fre_reg_req_t;
    typedef struct packed {
        logic erase;
        logic prog;
        logic [14:0] addr;
        logic [13:0] data;
    } fre_flash_cmd_t;
endpackage

// ---- fre_latch_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module fre_latch_mem
    import fre_pkg::*;
#(
    parameter int unsigned DEPTH = LATCHES,
    parameter int unsigned W = 14,
    parameter logic [W-1:0] BLANK = BLANK_WORD
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // write side
    input wire logic we_in,
    input wire logic [$clog2(DEPTH)-1:0] waddr_in,
    input wire logic [W-1:0] wdata_in,
    input wire logic clear_in,
    // read side
    input wire logic [$clog2(DEPTH)-1:0] raddr_in,
    output logic [W-1:0] rdata_out
);
    logic [W-1:0] mem_q [DEPTH];

    // unloaded entries stay blank so a partial row programs them as blank
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                mem_q[i] <= BLANK;
            end else if (clear_in) begin
                mem_q[i] <= BLANK;
            end else if (we_in && waddr_in == i) begin
                mem_q[i] <= wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= BLANK;
        end else begin
            rdata_out <= mem_q[raddr_in];
        end
    end
endmodule
`default_nettype wire

// ---- fre_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module fre_timer
    import fre_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic load_in,
    input wire logic [TMR_W-1:0] count_in,
    output logic done_out
);
    logic [TMR_W-1:0] cnt_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else if (load_in) begin
            cnt_q <= count_in;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // last cycle of the loaded span
    assign done_out = (cnt_q == TMR_W'(1));
endmodule
`default_nettype wire

// ---- fre_seq.sv ----
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fre_seq
    import fre_pkg::*;
#(
    parameter int unsigned ERASE_CLKS = ERASE_CYCLES,
    parameter int unsigned PROG_CLKS = ERASE_CYCLES
) (
    // clock and resets
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic por_n_in,
    // register port
    input wire fre_reg_req_t reg_in,
    output logic [7:0] rdata_out,
    // core control
    output logic core_nop_out,
    output logic core_stall_out,
    // flash array commands
    output fre_flash_cmd_t flash_cmd_out
);

    ////////////////////////////////////////////////////////////////////////
    // registers and decode

    logic [13:0] data_q;
    logic [14:0] addr_q;
    logic rd_q;
    logic wr_q;
    logic write_enable_bit_q;
    logic write_error_flag_q;
    logic free_q;
    logic latch_load_only_q;
    logic config_space_select_q;
    logic busy_mark_q;
    logic [9:0] row_q;
    fre_key_st_t key_q;
    fre_seq_st_t st_q;
    fre_op_t op_q;
    fre_op_t op_d;
    logic [5:0] strm_idx_q;
    logic [4:0] rd_idx_q;
    logic rd_vld_q;
    logic any_acc;
    logic key_wr;
    logic ctl_wr;
    logic wr_try;
    logic start_go;
    logic strm_on;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic tmr_done;
    logic [13:0] latch_rdata;
    logic latch_clr;

    assign any_acc = reg_in.wr || reg_in.rd;
    assign key_wr = reg_in.wr && reg_in.addr == REG_KEY;
    assign ctl_wr = reg_in.wr && reg_in.addr == REG_CTRL;
    assign wr_try = ctl_wr && reg_in.wdata[CTL_WR];

    // enable and select come from the same write that sets write-start
    assign start_go = wr_try && key_q == KEY_GOT2
        && reg_in.wdata[CTL_WRITE_ENABLE_BIT]
        && !reg_in.wdata[CTL_CONFIG_SPACE_SELECT]
        && st_q == SEQ_IDLE;

    always_comb begin
        if (reg_in.wdata[CTL_FREE]) begin
            op_d = OP_ERASE;
        end else if (reg_in.wdata[CTL_LATCH_LOAD_ONLY]) begin
            op_d = OP_LOAD;
        end else begin
            op_d = OP_PROG;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address and data registers

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            addr_q <= '0;
        end else if (reg_in.wr && reg_in.addr == REG_ADDR_LO) begin
            addr_q[7:0] <= reg_in.wdata;
        end else if (reg_in.wr && reg_in.addr == REG_ADDR_HI) begin
            addr_q[14:8] <= reg_in.wdata[6:0];
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            data_q <= '0;
        end else if (reg_in.wr && reg_in.addr == REG_DATA_LO) begin
            data_q[7:0] <= reg_in.wdata;
        end else if (reg_in.wr && reg_in.addr == REG_DATA_HI) begin
            data_q[13:8] <= reg_in.wdata[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            config_space_select_q <= 1'b0;
            latch_load_only_q <= 1'b0;
            write_enable_bit_q <= 1'b0;
        end else if (ctl_wr) begin
            config_space_select_q <= reg_in.wdata[CTL_CONFIG_SPACE_SELECT];
            latch_load_only_q <= reg_in.wdata[CTL_LATCH_LOAD_ONLY];
            write_enable_bit_q <= reg_in.wdata[CTL_WRITE_ENABLE_BIT];
        end
    end

    // erase select is cleared by hardware when the erase ends
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            free_q <= 1'b0;
        end else if (ctl_wr) begin
            free_q <= reg_in.wdata[CTL_FREE];
        end else if (st_q == SEQ_DONE && op_q == OP_ERASE) begin
            free_q <= 1'b0;
        end
    end

    // start bits: software writes of 0 are ignored, hardware clears
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_q <= 1'b0;
        end else if (start_go) begin
            wr_q <= 1'b1;
        end else if (st_q == SEQ_DONE) begin
            wr_q <= 1'b0;
        end
    end

    // no read engine here, so a read request completes at once
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_q <= 1'b0;
        end else if (ctl_wr && reg_in.wdata[CTL_RD]) begin
            rd_q <= 1'b1;
        end else begin
            rd_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error flag, kept across the ordinary reset

    // the mark survives arst so an interrupted operation is still seen
    always_ff @(posedge mclk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            busy_mark_q <= 1'b0;
        end else if (start_go) begin
            busy_mark_q <= 1'b1;
        end else if (st_q == SEQ_DONE || st_q == SEQ_IDLE) begin
            busy_mark_q <= 1'b0;
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            write_error_flag_q <= 1'b0;
        end else if (busy_mark_q && st_q == SEQ_IDLE) begin
            write_error_flag_q <= 1'b1;
        end else if (wr_try && !start_go) begin
            write_error_flag_q <= 1'b1;
        end else if (ctl_wr) begin
            write_error_flag_q <= reg_in.wdata[CTL_WRITE_ERROR_FLAG];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unlock tracker

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            key_q <= KEY_IDLE;
        end else begin
            case (key_q)
                KEY_IDLE: begin
                    if (key_wr && reg_in.wdata == KEY_FIRST) begin
                        key_q <= KEY_GOT1;
                    end
                end
                KEY_GOT1: begin
                    if (key_wr && reg_in.wdata == KEY_SECOND) begin
                        key_q <= KEY_GOT2;
                    end else if (any_acc) begin
                        key_q <= KEY_IDLE;
                    end
                end
                KEY_GOT2: begin
                    // consumed by the start write or dropped by any other
                    if (any_acc) begin
                        key_q <= KEY_IDLE;
                    end
                end
                default: begin
                    key_q <= KEY_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    assign tmr_load = start_go ||
        (st_q == SEQ_SETUP && tmr_done && op_q != OP_LOAD);
    always_comb begin
        if (start_go) begin
            tmr_val = TMR_W'(NOP_CYCLES);
        end else if (op_q == OP_ERASE) begin
            tmr_val = TMR_W'(ERASE_CLKS);
        end else begin
            tmr_val = TMR_W'(PROG_CLKS);
        end
    end

    fre_timer u_timer (
        .clk_in(mclk_in),
        .rst_n_in(arst_n_in),
        .load_in(tmr_load),
        .count_in(tmr_val),
        .done_out(tmr_done)
    );

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= SEQ_IDLE;
            op_q <= OP_LOAD;
            row_q <= '0;
        end else begin
            case (st_q)
                SEQ_IDLE: begin
                    if (start_go) begin
                        st_q <= SEQ_SETUP;
                        op_q <= op_d;
                        row_q <= addr_q[14:5];
                    end
                end
                SEQ_SETUP: begin
                    if (tmr_done) begin
                        st_q <= (op_q == OP_LOAD) ? SEQ_DONE : SEQ_STALL;
                    end
                end
                SEQ_STALL: begin
                    if (tmr_done) begin
                        st_q <= SEQ_DONE;
                    end
                end
                SEQ_DONE: begin
                    st_q <= SEQ_IDLE;
                end
                default: begin
                    st_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    // clocks keep running through the stall; only the core is held
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            core_nop_out <= 1'b0;
            core_stall_out <= 1'b0;
        end else if (start_go) begin
            core_nop_out <= 1'b1;
        end else if (st_q == SEQ_SETUP && tmr_done) begin
            core_nop_out <= 1'b0;
            core_stall_out <= (op_q != OP_LOAD);
        end else if (st_q == SEQ_STALL && tmr_done) begin
            core_stall_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write latches and flash streaming

    assign latch_clr = st_q == SEQ_DONE && op_q != OP_LOAD;
    assign strm_on = st_q == SEQ_STALL && op_q == OP_PROG &&
        !strm_idx_q[5];

    fre_latch_mem u_latch (
        .clk_in(mclk_in),
        .rst_n_in(arst_n_in),
        .we_in(start_go && op_d != OP_ERASE),
        .waddr_in(addr_q[4:0]),
        .wdata_in(data_q),
        .clear_in(latch_clr),
        .raddr_in(strm_idx_q[4:0]),
        .rdata_out(latch_rdata)
    );

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            strm_idx_q <= '0;
            rd_vld_q <= 1'b0;
            rd_idx_q <= '0;
        end else begin
            strm_idx_q <= strm_on ? strm_idx_q + 6'h01 :
                (st_q == SEQ_STALL ? strm_idx_q : 6'h00);
            rd_vld_q <= strm_on;
            rd_idx_q <= strm_idx_q[4:0];
        end
    end

    // programming only writes words; no erase is issued with it
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flash_cmd_out <= '0;
        end else begin
            flash_cmd_out.erase <= st_q == SEQ_SETUP && tmr_done &&
                op_q == OP_ERASE;
            flash_cmd_out.prog <= rd_vld_q;
            if (st_q == SEQ_SETUP && op_q == OP_ERASE) begin
                flash_cmd_out.addr <= {row_q, 5'h00};
            end else begin
                flash_cmd_out.addr <= {row_q, rd_idx_q};
            end
            flash_cmd_out.data <= latch_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= '0;
        end else if (!reg_in.rd) begin
            rdata_out <= '0;
        end else begin
            case (reg_in.addr)
                REG_DATA_LO: rdata_out <= data_q[7:0];
                REG_DATA_HI: rdata_out <= {2'h0, data_q[13:8]};
                REG_ADDR_LO: rdata_out <= addr_q[7:0];
                REG_ADDR_HI: rdata_out <= {1'b1, addr_q[14:8]};
                REG_CTRL: rdata_out <= {1'b1, config_space_select_q,
                    latch_load_only_q, free_q, write_error_flag_q,
                    write_enable_bit_q, wr_q, rd_q};
                default: rdata_out <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    a_start_needs_key: assert property (
        $rose(core_nop_out) |-> $past(key_q) == KEY_GOT2 && wr_q)
        else $error("operation started without full unlock");
    a_no_enable_idle: assert property (
        wr_try && !reg_in.wdata[CTL_WRITE_ENABLE_BIT] |=>
        !core_nop_out && !wr_q)
        else $error("operation started with write-enable clear");
    a_nop_two_slots: assert property (
        $rose(core_nop_out) |-> core_nop_out[*8] ##1 !core_nop_out)
        else $error("forced no-operation span not two slots");
    a_load_no_stall: assert property (
        start_go && op_d == OP_LOAD |-> ##1 (!core_stall_out)[*8]
        ##1 !core_stall_out)
        else $error("latch load stalled the core");
    a_stall_follows: assert property (
        $fell(core_nop_out) && op_q != OP_LOAD |-> core_stall_out)
        else $error("erase or program did not stall the core");
    a_row_bound: assert property (
        flash_cmd_out.prog |-> flash_cmd_out.addr[14:5] == row_q)
        else $error("program word left its row");
    a_erase_row_base: assert property (
        flash_cmd_out.erase |-> flash_cmd_out.addr[4:0] == 5'h00)
        else $error("erase not aligned to a row");
    a_latch_blank: assert property (
        st_q == SEQ_DONE && op_q != OP_LOAD |=> ##1
        latch_rdata == BLANK_WORD)
        else $error("latches not blank after operation");
    a_wr_hw_clear: assert property (
        st_q == SEQ_DONE |=> !wr_q && !core_stall_out)
        else $error("write-start not cleared at completion");
    a_unlock_abort: assert property (
        key_q == KEY_GOT1 && any_acc && !key_wr |=> key_q == KEY_IDLE)
        else $error("unlock tracker kept state after stray access");

    c_erase: cover property (flash_cmd_out.erase);
    c_program: cover property ($fell(flash_cmd_out.prog));
    c_load_only: cover property (start_go && op_d == OP_LOAD);
    c_abort: cover property (key_q == KEY_GOT2 && any_acc && !start_go);
endmodule
`default_nettype wire

// ---- fre_seq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fre_pkg::*;
    // short operation time keeps the run small; all stall counts follow it
    localparam int OPC = 50;
    logic mclk_in = 1'b0;
    logic arst_n = 1'b0;
    logic por_n = 1'b0;
    fre_reg_req_t req = '0;
    logic [7:0] rdata;
    logic nop;
    logic stall;
    fre_flash_cmd_t cmd;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int nop_cnt, stall_cnt, erase_cnt, prog_cnt;
    int nop_first, stall_first, t_take;
    logic [14:0] erase_addr;
    logic [14:0] pa [0:63];
    logic [13:0] pd [0:63];
    logic [13:0] exp_l [0:31];
    logic [31:0] rnd = 32'h4375509d;
    logic [7:0] rv;
    logic [9:0] row;
    logic [14:0] fa;

    always #12.5 mclk_in = ~mclk_in;

    fre_seq #(.ERASE_CLKS(OPC), .PROG_CLKS(OPC)) DUT (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n),
        .por_n_in(por_n),
        .reg_in(req),
        .rdata_out(rdata),
        .core_nop_out(nop),
        .core_stall_out(stall),
        .flash_cmd_out(cmd)
    );

    ////////////////////////////////////////////////////////////////////////
    // monitor: counts core and flash activity per operation
    always @(posedge mclk_in) begin
        cyc++;
        if (nop === 1'b1) begin
            if (nop_first < 0) nop_first = cyc;
            nop_cnt++;
        end
        if (stall === 1'b1) begin
            if (stall_first < 0) stall_first = cyc;
            stall_cnt++;
        end
        if (cmd.erase === 1'b1) begin
            erase_cnt++;
            erase_addr = cmd.addr;
        end
        if (cmd.prog === 1'b1 && prog_cnt < 64) begin
            pa[prog_cnt] = cmd.addr;
            pd[prog_cnt] = cmd.data;
            prog_cnt++;
        end
        if (req.wr && req.addr == REG_CTRL && req.wdata[CTL_WR]) t_take = cyc;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_in);
        req <= '0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk_in);
        req <= '0;
        #1 d = rdata;
    endtask

    task automatic put_word(input logic [14:0] a, input logic [13:0] d);
        wr_reg(REG_DATA_LO, d[7:0]);
        wr_reg(REG_DATA_HI, {2'b00, d[13:8]});
        wr_reg(REG_ADDR_LO, a[7:0]);
        wr_reg(REG_ADDR_HI, {1'b0, a[14:8]});
    endtask

    task automatic clr;
        #1;
        nop_cnt = 0;
        stall_cnt = 0;
        erase_cnt = 0;
        prog_cnt = 0;
        nop_first = -1;
        stall_first = -1;
        t_take = -1;
    endtask

    task automatic go(input logic [7:0] ctrl);
        clr();
        wr_reg(REG_KEY, KEY_FIRST);
        wr_reg(REG_KEY, KEY_SECOND);
        wr_reg(REG_CTRL, ctrl);
    endtask

    task automatic check_op(input int n_nop, input int n_st, input int n_pr,
                            input int n_er);
        chk(nop_cnt, n_nop);
        chk(stall_cnt, n_st);
        chk(prog_cnt, n_pr);
        chk(erase_cnt, n_er);
        if (n_nop != 0) chk(nop_first, t_take + 1);
        if (n_st != 0) chk(stall_first, nop_first + NOP_CYCLES);
    endtask

    // every latch of the row goes out in order; afterwards all latches blank
    task automatic chk_row(input logic [9:0] r);
        for (int i = 0; i < 32; i++) begin
            chk(pa[i], {r, i[4:0]});
            chk(pd[i], exp_l[i]);
            exp_l[i] = BLANK_WORD;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk_in);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        for (int i = 0; i < 32; i++) exp_l[i] = BLANK_WORD;
        repeat (8) @(posedge mclk_in);
        arst_n <= 1'b1;
        por_n <= 1'b1;
        rd_reg(REG_CTRL, rv);
        chk(rv, 8'h80);
        rd_reg(REG_ADDR_HI, rv);
        chk(rv, 8'h80);
        rd_reg(REG_KEY, rv);
        chk(rv, 8'h00);
        rd_reg(3'h6, rv);
        chk(rv, 8'h00);
        // full row: 31 latch loads then the programming load
        rnd = lfsr(rnd);
        row = rnd[9:0];
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            exp_l[i] = rnd[13:0];
            put_word({row, i[4:0]}, rnd[13:0]);
            if (i < 31) begin
                go(8'h26);
                repeat (NOP_CYCLES + 4) @(posedge mclk_in);
                check_op(NOP_CYCLES, 0, 0, 0);
            end else begin
                go(8'h06);
                repeat (NOP_CYCLES + OPC + 4) @(posedge mclk_in);
                check_op(NOP_CYCLES, OPC, LATCHES, 0);
            end
        end
        chk_row(row);
        // interrupted unlock, then start with writes disabled: no load
        rnd = lfsr(rnd);
        row = rnd[9:0];
        put_word({row, 5'd3}, 14'h0123);
        clr();
        wr_reg(REG_KEY, KEY_FIRST);
        wr_reg(REG_ADDR_LO, {row[2:0], 5'd3});
        wr_reg(REG_KEY, KEY_SECOND);
        wr_reg(REG_CTRL, 8'h26);
        repeat (NOP_CYCLES + 4) @(posedge mclk_in);
        check_op(0, 0, 0, 0);
        rd_reg(REG_CTRL, rv);
        chk(rv[CTL_WRITE_ERROR_FLAG], 1'b1);
        put_word({row, 5'd7}, 14'h0456);
        go(8'h22);
        repeat (NOP_CYCLES + 4) @(posedge mclk_in);
        check_op(0, 0, 0, 0);
        // config select set in the start write: refused, no latch load
        go(8'h46);
        repeat (NOP_CYCLES + 4) @(posedge mclk_in);
        check_op(0, 0, 0, 0);
        // software clears the error flag; read-start clears itself
        wr_reg(REG_CTRL, 8'h01);
        rd_reg(REG_CTRL, rv);
        chk(rv, 8'h80);
        rnd = lfsr(rnd);
        exp_l[12] = rnd[13:0];
        put_word({row, 5'd12}, rnd[13:0]);
        go(8'h06);
        repeat (NOP_CYCLES + OPC + 4) @(posedge mclk_in);
        check_op(NOP_CYCLES, OPC, LATCHES, 0);
        chk_row(row);
        // row erase from an address inside the row
        rnd = lfsr(rnd);
        fa = rnd[14:0];
        put_word(fa, 14'h0000);
        go(8'h16);
        repeat (NOP_CYCLES + 10) @(posedge mclk_in);
        // the register port still answers while the core is held
        rd_reg(REG_CTRL, rv);
        chk(rv[CTL_WR], 1'b1);
        repeat (OPC) @(posedge mclk_in);
        check_op(NOP_CYCLES, OPC, 0, 1);
        chk(erase_addr, {fa[14:5], 5'h00});
        rd_reg(REG_CTRL, rv);
        chk(rv & 8'h12, 8'h00);
        // reset in the middle of an erase leaves the error flag set
        go(8'h16);
        repeat (20) @(posedge mclk_in);
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk(stall, 1'b0);
        arst_n <= 1'b1;
        rd_reg(REG_CTRL, rv);
        chk(rv[CTL_WRITE_ERROR_FLAG], 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
